// ==== gcr_config_bank.sv ====
`timescale 1ns/1ps
`include "gcr_defs.svh"
// Contract
// [RULE1] A set holdover mask bit blocks the holdover interrupt of the second, third or fourth loop on bits 2, 1, 0.
// [RULE2] Mask bit 3 blocks the first loop's holdover interrupt, and all mask bits reset to zero.
// [RULE3] The slave address is the default 0x69 unless the override enable bit 7 is set.
// [RULE4] With override on, bits 6:2 replace the upper five address bits 11010.
// [RULE5] A lock pattern of 01 or 10 means the fuse memory is locked, 00 or 11 means unlocked.
// [RULE6] With pad fast enable clear the pads are plain open drain without pull-up, and SPI ignores the bit.
// [RULE7] Wake-up bit 4 at zero selects the manual wake-up sequence.
// [RULE8] Writing 0x01 to offset FE asserts the digital reset at once, and the register reads back.
// [RULE9] Writing 0 to bit 0 of offset FE releases the digital reset through a per-domain synchronizer.
// [RULE10] Offset FF is a readable and writable page select on every page.
// [RULE11] After a page write, accesses below FF go to the newly selected page until the next page write.
module gcr_config_bank #(
   parameter int unsigned SYNC_STAGES  = `GCR_SYNC_STAGES,
   parameter logic [7:0]  GENERIC_PAGE = `GCR_GENERIC_PAGE
) (
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   input  wire logic                reg_write_i,
   input  wire logic                reg_read_i,
   input  wire gcr_pkg::gcr_byte_t  reg_addr_i,
   input  wire gcr_pkg::gcr_byte_t  reg_wdata_i,
   input  wire gcr_pkg::gcr_loops_t holdover_event_i,
   input  wire logic                spi_mode_i,
   output gcr_pkg::gcr_byte_t       reg_rdata_o,
   output logic                     reg_rvalid_o,
   output gcr_pkg::gcr_byte_t       page_o,
   output gcr_pkg::gcr_addr7_t      slave_address_o,
   output gcr_pkg::gcr_loops_t      holdover_irq_o,
   output logic                     fuse_locked_o,
   output logic                     pad_fast_mode_enable_o,
   output logic                     manual_wakeup_o,
   output logic                     shared_oscillator_decrement_enable_o,
   output gcr_pkg::gcr_byte_t       chip_variant_o,
   output logic                     digital_reset_o
);
   import gcr_pkg::*;

   gcr_reset_if rst_if ();

   gcr_byte_t  mask_reg,    mask_next;
   gcr_byte_t  variant_reg, variant_next;
   gcr_byte_t  addr_reg,    addr_next;
   gcr_byte_t  pattern_reg, pattern_next;
   gcr_byte_t  osc_reg,     osc_next;
   gcr_byte_t  soft_reg,    soft_next;
   gcr_byte_t  page_reg,    page_next;
   gcr_byte_t  rdata_reg,   rdata_next;
   logic       rvalid_reg,  rvalid_next;
   gcr_addr7_t slave_reg,   slave_next;
   gcr_loops_t irq_reg,     irq_next;
   logic       locked_reg,  locked_next;
   logic       fast_reg,    fast_next;
   logic       manual_reg,  manual_next;
   logic       decr_reg,    decr_next;

   // Offsets below FF exist only while the generic page is selected
   function automatic logic bank_hit(input gcr_byte_t addr, input gcr_byte_t page, input gcr_byte_t off);
      bank_hit = (addr == off) && ((off == `GCR_OFF_PAGE_SELECT) || (page == GENERIC_PAGE)); // RULE10 RULE11
   endfunction : bank_hit

   always_comb
   begin
      mask_next    = mask_reg;
      variant_next = variant_reg;
      addr_next    = addr_reg;
      pattern_next = pattern_reg;
      osc_next     = osc_reg;
      soft_next    = soft_reg;
      page_next    = page_reg;
      rdata_next   = 8'h00;
      rvalid_next  = reg_read_i;
      if (reg_write_i)
      begin
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_HOLDOVER_MASK))
            mask_next = reg_wdata_i; // RULE1 RULE2
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_CHIP_VARIANT))
            variant_next = reg_wdata_i;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_ADDR_OVERRIDE))
            addr_next = reg_wdata_i; // RULE3 RULE4
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_LOCK_PAD_WAKE))
            pattern_next = reg_wdata_i;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_OSC_OVERRIDE))
            osc_next = reg_wdata_i;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_SOFT_RESET))
            soft_next = reg_wdata_i; // RULE8 RULE9
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_PAGE_SELECT))
            page_next = reg_wdata_i; // RULE10 RULE11
      end
      // Unmapped offsets and offsets below FF on foreign pages read as zero
      if (reg_read_i)
      begin
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_HOLDOVER_MASK))
            rdata_next = mask_reg;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_CHIP_VARIANT))
            rdata_next = variant_reg;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_ADDR_OVERRIDE))
            rdata_next = addr_reg;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_LOCK_PAD_WAKE))
            rdata_next = pattern_reg;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_OSC_OVERRIDE))
            rdata_next = osc_reg;
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_SOFT_RESET))
            rdata_next = soft_reg; // RULE8
         if (bank_hit(reg_addr_i, page_reg, `GCR_OFF_PAGE_SELECT))
            rdata_next = page_reg; // RULE10
      end
   end

   // Derived controls lag their register by one clock, keeping every output on a flop
   always_comb
   begin
      irq_next    = holdover_event_i & ~mask_reg[`GCR_MASK_FIRST:`GCR_MASK_FOURTH]; // RULE1 RULE2
      slave_next  = `GCR_ADDR_DEFAULT; // RULE3
      if (addr_reg[`GCR_ADDR_EN_BIT])
      begin
         slave_next = {addr_reg[`GCR_ADDR_HI_MSB:`GCR_ADDR_HI_LSB], `GCR_ADDR_LOW_BITS}; // RULE4
      end
      locked_next = pattern_reg[`GCR_LOCK_MSB] ^ pattern_reg[`GCR_LOCK_LSB]; // RULE5
      fast_next   = pattern_reg[`GCR_PAD_FAST_BIT] & ~spi_mode_i; // RULE6
      manual_next = ~pattern_reg[`GCR_WAKE_AUTO_BIT]; // RULE7
      decr_next   = osc_reg[`GCR_OSC_DECR_BIT];
   end

   // The bank itself is outside the soft reset, else the request would clear itself
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         mask_reg    <= `GCR_RST_BYTE; // RULE2
         variant_reg <= `GCR_RST_BYTE;
         addr_reg    <= `GCR_RST_BYTE;
         pattern_reg <= `GCR_RST_BYTE;
         osc_reg     <= `GCR_RST_BYTE;
         soft_reg    <= `GCR_RST_BYTE;
         page_reg    <= `GCR_RST_BYTE;
         rdata_reg   <= 8'h00;
         rvalid_reg  <= 1'b0;
         slave_reg   <= `GCR_ADDR_DEFAULT;
         irq_reg     <= 4'h0;
         locked_reg  <= 1'b0;
         fast_reg    <= 1'b0;
         manual_reg  <= 1'b1;
         decr_reg    <= 1'b0;
      end
      else
      begin
         mask_reg    <= mask_next;
         variant_reg <= variant_next;
         addr_reg    <= addr_next;
         pattern_reg <= pattern_next;
         osc_reg     <= osc_next;
         soft_reg    <= soft_next;
         page_reg    <= page_next;
         rdata_reg   <= rdata_next;
         rvalid_reg  <= rvalid_next;
         slave_reg   <= slave_next;
         irq_reg     <= irq_next;
         locked_reg  <= locked_next;
         fast_reg    <= fast_next;
         manual_reg  <= manual_next;
         decr_reg    <= decr_next;
      end
   end

   assign rst_if.request = soft_reg[`GCR_SOFT_RESET_BIT]; // RULE8

   gcr_reset_sync #(
      .STAGES (SYNC_STAGES)
   ) u_reset_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .rst_if  (rst_if.sync)
   );

   assign reg_rdata_o                          = rdata_reg;
   assign reg_rvalid_o                         = rvalid_reg;
   assign page_o                               = page_reg;
   assign slave_address_o                      = slave_reg;
   assign holdover_irq_o                       = irq_reg;
   assign fuse_locked_o                        = locked_reg;
   assign pad_fast_mode_enable_o               = fast_reg;
   assign manual_wakeup_o                      = manual_reg;
   assign shared_oscillator_decrement_enable_o = decr_reg;
   assign chip_variant_o                       = variant_reg;
   assign digital_reset_o                      = rst_if.digital_reset;

   mask_gates_irq_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
      !$past(reset_i) |-> holdover_irq_o == ($past(holdover_event_i) & ~$past(mask_reg[3:0])))
      else $error("Holdover interrupt not gated by mask");

   first_loop_mask_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
      mask_reg[`GCR_MASK_FIRST] |=> !holdover_irq_o[3])
      else $error("First loop holdover interrupt leaked through mask");

   mask_reset_a: assert property (@(posedge clk_i) // RULE2
      reset_i |=> mask_reg == 8'h00)
      else $error("Holdover mask not cleared by reset");

   default_addr_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
      !addr_reg[`GCR_ADDR_EN_BIT] |=> slave_address_o == 7'h69)
      else $error("Default slave address not used");

   override_addr_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
      addr_reg[`GCR_ADDR_EN_BIT] |=> slave_address_o == {$past(addr_reg[6:2]), 2'h1})
      else $error("Override slave address wrong");

   fuse_lock_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
      (pattern_reg[7:6] == 2'h1 || pattern_reg[7:6] == 2'h2) |=> fuse_locked_o)
      else $error("Lock pattern not decoded as locked");

   pad_mode_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
      (!pattern_reg[`GCR_PAD_FAST_BIT] || spi_mode_i) |=> !pad_fast_mode_enable_o)
      else $error("Pad fast mode enabled while cleared or in SPI");

   wakeup_sel_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
      !pattern_reg[`GCR_WAKE_AUTO_BIT] |=> manual_wakeup_o)
      else $error("Manual wake-up not selected");

   reset_assert_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
      (reg_write_i && reg_addr_i == 8'hfe && page_reg == GENERIC_PAGE && reg_wdata_i == 8'h01)
      |=> digital_reset_o)
      else $error("Soft reset not asserted after write");

   reset_release_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
      $fell(soft_reg[0]) |-> digital_reset_o ##[1:4] !digital_reset_o)
      else $error("Soft reset release not synchronized");

   page_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
      (reg_read_i && reg_addr_i == 8'hff) |=> reg_rvalid_o && reg_rdata_o == $past(page_reg))
      else $error("Page select readback wrong");

   page_route_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
      (reg_write_i && reg_addr_i == 8'h28 && page_reg != GENERIC_PAGE) |=> $stable(mask_reg))
      else $error("Write reached bank on foreign page");
endmodule : gcr_config_bank

// ==== gcr_defs.svh ====
`ifndef GCR_DEFS_SVH
`define GCR_DEFS_SVH

`define GCR_OFF_HOLDOVER_MASK   8'h28
`define GCR_OFF_CHIP_VARIANT    8'h29
`define GCR_OFF_ADDR_OVERRIDE   8'h2a
`define GCR_OFF_LOCK_PAD_WAKE   8'h2f
`define GCR_OFF_OSC_OVERRIDE    8'he7
`define GCR_OFF_SOFT_RESET      8'hfe
`define GCR_OFF_PAGE_SELECT     8'hff

`define GCR_RST_BYTE            8'h00

`define GCR_MASK_FIRST          3
`define GCR_MASK_SECOND         2
`define GCR_MASK_THIRD          1
`define GCR_MASK_FOURTH         0

`define GCR_ADDR_EN_BIT         7
`define GCR_ADDR_HI_MSB         6
`define GCR_ADDR_HI_LSB         2
`define GCR_ADDR_DEFAULT        7'h69
`define GCR_ADDR_LOW_BITS       2'h1

`define GCR_LOCK_MSB            7
`define GCR_LOCK_LSB            6
`define GCR_PAD_FAST_BIT        5
`define GCR_WAKE_AUTO_BIT       4
`define GCR_OSC_DECR_BIT        7
`define GCR_SOFT_RESET_BIT      0

`define GCR_GENERIC_PAGE        8'h00
`define GCR_SYNC_STAGES         2

`endif

// ==== gcr_host_model.sv ====
`timescale 1ns/1ps
module gcr_host_model (
   input  wire logic               clk_i,
   output logic                    reg_write_o,
   output logic                    reg_read_o,
   output gcr_pkg::gcr_byte_t      reg_addr_o,
   output gcr_pkg::gcr_byte_t      reg_wdata_o,
   input  wire gcr_pkg::gcr_byte_t reg_rdata_i,
   input  wire logic               reg_rvalid_i
);
   import gcr_pkg::*;
   initial
   begin
      reg_write_o = 1'b0;
      reg_read_o  = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Soft reset and page select are plain byte writes from the host
   task automatic wr(input gcr_byte_t a, input gcr_byte_t d);
      @(negedge clk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_write_o = 1'b1;
      @(negedge clk_i);
      reg_write_o = 1'b0;
      // Released lines do not keep the last value
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask : wr
   task automatic rd(input gcr_byte_t a, output gcr_byte_t d, output logic v);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_read_o = 1'b1;
      @(negedge clk_i);
      reg_read_o = 1'b0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
      v          = reg_rvalid_i;
   endtask : rd
endmodule : gcr_host_model

// ==== gcr_pkg.sv ====
package gcr_pkg;
   typedef logic [7:0] gcr_byte_t;
   typedef logic [6:0] gcr_addr7_t;
   typedef logic [3:0] gcr_loops_t;
endpackage : gcr_pkg

// ==== gcr_reset_if.sv ====
`timescale 1ns/1ps
interface gcr_reset_if;
   logic request;
   logic digital_reset;
   modport bank (output request, input digital_reset);
   modport sync (input request, output digital_reset);
endinterface : gcr_reset_if

// ==== gcr_reset_sync.sv ====
`timescale 1ns/1ps
module gcr_reset_sync #(
   parameter int unsigned STAGES = 2
) (
   input  wire logic   clk_i,
   input  wire logic   reset_i,
   gcr_reset_if.sync   rst_if
);
   logic [STAGES-1:0] sync_reg;
   logic [STAGES-1:0] sync_next;

   // Release walks through the chain so it leaves on a clean edge
   always_comb
   begin
      sync_next = {sync_reg[STAGES-2:0], 1'b0}; // RULE9
      if (reset_i)
      begin
         sync_next = '1;
      end
   end

   // Assertion does not wait for the clock
   always_ff @(posedge clk_i or posedge rst_if.request)
   begin
      if (rst_if.request)
      begin
         sync_reg <= '1; // RULE8
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign rst_if.digital_reset = sync_reg[STAGES-1];
endmodule : gcr_reset_sync

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import gcr_pkg::*;
   logic       clk_i, reset_i, spi_mode_i, wr_s, rd_s, rvalid, locked, fast, manual, decr, dreset;
   gcr_byte_t  addr, wdata, rdata, page, variant;
   gcr_addr7_t slave;
   gcr_loops_t event_i, irq;
   int         errors = 0;
   int         comparisons = 0;
   int         cycles = 0;
   gcr_host_model host (.clk_i(clk_i), .reg_write_o(wr_s), .reg_read_o(rd_s), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   gcr_config_bank #(.SYNC_STAGES(2)) dut (.clk_i(clk_i), .reset_i(reset_i), .reg_write_i(wr_s),
      .reg_read_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata), .holdover_event_i(event_i),
      .spi_mode_i(spi_mode_i), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .page_o(page),
      .slave_address_o(slave), .holdover_irq_o(irq), .fuse_locked_o(locked),
      .pad_fast_mode_enable_o(fast), .manual_wakeup_o(manual),
      .shared_oscillator_decrement_enable_o(decr), .chip_variant_o(variant), .digital_reset_o(dreset));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input string n, input gcr_byte_t a, input gcr_byte_t e);
      gcr_byte_t d;
      logic      v;
      host.rd(a, d, v);
      chk({n, " valid"}, 8'h01, {7'h00, v});
      chk(n, e, d);
   endtask : rchk
   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic t_reset;
      gcr_byte_t offs [7] = '{8'h28, 8'h29, 8'h2a, 8'h2f, 8'he7, 8'hfe, 8'hff};
      chk("slave", 8'h69, {1'b0, slave});
      chk("manual", 8'h01, {7'h00, manual});
      chk("irq", 8'h00, {4'h0, irq});
      chk("page", 8'h00, page);
      foreach (offs[i]) rchk("reset value", offs[i], 8'h00);
      chk("dreset", 8'h00, {7'h00, dreset});
      $display("test reset done");
   endtask : t_reset
   task automatic t_mask;
      gcr_byte_t m;
      event_i = 4'hf;
      @(negedge clk_i);
      chk("irq unmasked", 8'h0f, {4'h0, irq});
      for (int i = 0; i < 4; i++)
      begin
         m = 8'h01 << i;
         host.wr(8'h28, m);
         @(negedge clk_i);
         chk("irq", {4'h0, ~m[3:0]}, {4'h0, irq});
         rchk("mask", 8'h28, m);
      end
      $display("test mask done");
   endtask : t_mask
   task automatic t_addr;
      host.wr(8'h2a, 8'h55);
      @(negedge clk_i);
      chk("slave", 8'h69, {1'b0, slave});
      host.wr(8'h2a, 8'hac);
      @(negedge clk_i);
      chk("slave", 8'h2d, {1'b0, slave});
      $display("test address done");
   endtask : t_addr
   task automatic t_pattern;
      logic [4:0] j;
      for (int k = 0; k < 32; k++)
      begin
         j          = k[4:0];
         spi_mode_i = j[4];
         host.wr(8'h2f, {j[3:0], 4'h0});
         @(negedge clk_i);
         chk("locked", {7'h00, j[3] ^ j[2]}, {7'h00, locked});
         chk("fast", {7'h00, j[1] & ~j[4]}, {7'h00, fast});
         chk("manual", {7'h00, ~j[0]}, {7'h00, manual});
      end
      $display("test pattern done");
   endtask : t_pattern
   task automatic t_soft;
      host.wr(8'h28, 8'h05);
      host.wr(8'hfe, 8'h01);
      chk("dreset on", 8'h01, {7'h00, dreset});
      rchk("soft reg", 8'hfe, 8'h01);
      rchk("mask kept", 8'h28, 8'h05);
      host.wr(8'hfe, 8'h00);
      @(negedge clk_i);
      chk("dreset sync", 8'h01, {7'h00, dreset});
      repeat (2) @(negedge clk_i);
      chk("dreset off", 8'h00, {7'h00, dreset});
      $display("test soft reset done");
   endtask : t_soft
   task automatic t_page;
      host.wr(8'h29, 8'h5a);
      host.wr(8'he7, 8'h80);
      @(negedge clk_i);
      chk("variant", 8'h5a, variant);
      chk("decr", 8'h01, {7'h00, decr});
      host.wr(8'hff, 8'h03);
      rchk("page reg", 8'hff, 8'h03);
      chk("page", 8'h03, page);
      host.wr(8'h29, 8'h11);
      host.wr(8'h28, 8'hff);
      rchk("other page", 8'h29, 8'h00);
      host.wr(8'hff, 8'h00);
      rchk("back page", 8'h29, 8'h5a);
      rchk("mask foreign", 8'h28, 8'h05);
      rchk("unmapped", 8'h30, 8'h00);
      $display("test page done");
   endtask : t_page
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         end_sim();
      end
   end
   initial
   begin
      reset_i    = 1'b1;
      spi_mode_i = 1'b0;
      event_i    = 4'h0;
      repeat (10) @(negedge clk_i);
      reset_i = 1'b0;
      chk("dreset held", 8'h01, {7'h00, dreset});
      repeat (3) @(negedge clk_i);
      t_reset();
      t_mask();
      t_addr();
      t_pattern();
      t_soft();
      t_page();
      end_sim();
   end
endmodule : tb_top
